// [common/uart_wakeup_pkg.sv]
`default_nettype none
package uart_wakeup_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // idle bit times per character: start + data + stop
  localparam logic [3:0] CHAR_BITS_8  = 4'hA;
  localparam logic [3:0] CHAR_BITS_9  = 4'hB;
  localparam logic [3:0] IDLE_CNT_RST = 4'h0;
  // data bit position of the address mark
  localparam logic [3:0] MSB_POS_8    = 4'h7;
  localparam logic [3:0] MSB_POS_9    = 4'h8;

  typedef enum logic [2:0] {
    STOP_NONE  = 3'b001,
    STOP_LIGHT = 3'b010,
    STOP_DEEP  = 3'b100
  } stop_mode_e;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_ARMED = 2'b10
  } clr_seq_e;

  typedef struct packed {
    logic nine_bit;
    logic wake_sel;
    logic quiet_count_start_select;
    logic loopback_enable;
    logic loop_source_select;
    logic single_wire_direction;
  } cfg_s;

  // also used as the eight interrupt enables, same bit order
  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } flags_s;

  localparam logic [7:0] TX_GRP  = 8'hC0;
  localparam logic [7:0] RX_GRP  = 8'h30;
  localparam logic [7:0] ERR_GRP = 8'h0F;

  typedef struct packed {
    logic [DATA_W:0] data;
    logic            noise;
    logic            framing;
    logic            parity;
  } rx_char_s;
endpackage
`default_nettype wire

// [design/sync2.sv]
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,  // module clock
  input  wire logic         rstn, // async reset, active low
  input  wire logic [W-1:0] d,    // asynchronous inputs
  output logic      [W-1:0] q     // synchronised copies
);
  logic [W-1:0] meta_q;

  // pins idle high, so both stages reset to ones
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [design/tx_fifo.sv]
`default_nettype none
module tx_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk,       // module clock
  input  wire logic         rstn,      // async reset, active low
  input  wire logic         clr,       // sync flush
  input  wire logic         en,        // clock enable, low freezes all but clr
  input  wire logic         in_valid,  // write request
  input  wire logic [W-1:0] in_data,   // write data
  output logic              in_ready,  // room for a word
  output logic              out_valid, // a word is held
  output logic      [W-1:0] out_data,  // oldest word
  input  wire logic         out_ready  // take oldest word
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push     = en && in_valid && in_ready;
  assign pop      = en && out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (clr) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q     <= cnt_d;
      in_ready  <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [design/uart_wakeup_flags_loop.sv]
`default_nettype none
module uart_wakeup_flags_loop
  import uart_wakeup_pkg::*;
#(
  parameter int unsigned FIFO_W = DATA_W,
  parameter int unsigned FIFO_D = FIFO_DEPTH
) (
  input  wire logic              clk,                // module clock
  input  wire logic              rstn,               // async reset, active low
  input  wire stop_mode_e        stop_mode,          // run, light or deep stop
  input  wire cfg_s              cfg,                // static configuration
  input  wire flags_s            irq_en,             // per source enables
  input  wire logic              sleep_set,          // pulse, put receiver to sleep
  input  wire logic              status_read,        // pulse, status read
  input  wire logic              data_read,          // pulse, data read
  input  wire logic              tx_ninth_bit,       // level, ninth bit to send
  input  wire logic              tx_wr_valid,        // write into tx buffer
  input  wire logic [FIFO_W-1:0] tx_wr_data,         // tx data word
  output logic                   tx_wr_ready,        // room in tx buffer
  input  wire logic              shifter_free,       // shifter can take a word
  input  wire logic              shifter_idle,       // shifter done, line high
  input  wire logic              tx_serial,          // shifter serial output
  output logic                   tx_load,            // pulse, word to shifter
  output logic       [FIFO_W:0]  tx_word,            // ninth bit and data
  input  wire logic              bit_tick,           // one pulse per bit time
  input  wire logic              rx_bit_tick,        // pulse, data bit sampled
  input  wire logic       [3:0]  rx_bit_pos,         // its position
  input  wire logic              rx_bit_val,         // its value
  input  wire logic              rx_char_valid,      // pulse, character complete
  input  wire rx_char_s          rx_char,            // character and errors
  input  wire logic              serial_in_pin,      // input pin level
  input  wire logic              serial_out_pin_i,   // output pin read back
  output logic                   serial_out_pin_o,   // output pin drive value
  output logic                   serial_out_pin_oe,  // output pin enable
  output logic                   serial_in_released, // input pin back to gpio
  output logic                   rx_line,            // line into receiver
  output logic                   receiver_sleep,     // sleep state
  output flags_s                 flags,              // status flags
  output logic       [DATA_W:0]  rx_data,            // received word
  output logic                   rx_ninth_bit,       // received ninth bit
  output logic                   tx_irq,             // transmit request
  output logic                   rx_irq,             // receive request
  output logic                   err_irq             // error request
);
  logic             run;
  logic             deep;
  logic [1:0]       pins_s;
  logic             line_d;
  logic             rx_line_q;
  logic             pin_o_q;
  logic             pin_oe_q;
  logic             released_q;
  logic [3:0]       idle_cnt_q;
  logic             quiet_hold_q;
  logic [3:0]       char_len;
  logic             idle_hit;
  logic             addr_hit;
  logic             wake_now;
  logic             sleep_q;
  clr_seq_e         seq_q;
  logic             clr_now;
  logic             take;
  logic             ovr;
  logic             quiet_set;
  logic             idle_arm_q;
  logic             rx_full_q;
  logic             idle_q;
  logic             overrun_q;
  logic             noise_q;
  logic             framing_q;
  logic             parity_q;
  logic [DATA_W:0]  rx_data_q;
  logic             tx_done_q;
  logic             tx_load_q;
  logic [FIFO_W:0]  tx_word_q;
  logic             fifo_ready;
  logic             fifo_valid;
  logic [FIFO_W-1:0] fifo_head;
  logic             pop;
  flags_s           flags_all;
  logic             tx_irq_q;
  logic             rx_irq_q;
  logic             err_irq_q;

  // clocks halt in any stop; deep stop also wipes state
  always_comb begin
    run  = 1'b1;
    deep = 1'b0;
    unique case (stop_mode)
      STOP_NONE:  run = 1'b1;
      STOP_LIGHT: run = 1'b0;
      STOP_DEEP: begin
        run  = 1'b0;
        deep = 1'b1;
      end
      default:    run = 1'b1;
    endcase
  end

  sync2 #(.W(2)) u_pin_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({serial_in_pin, serial_out_pin_i}),
    .q    (pins_s)
  );

  // receiver source selection
  always_comb begin
    line_d = pins_s[1];
    if (cfg.loopback_enable) begin
      if (cfg.loop_source_select && !cfg.single_wire_direction) begin
        line_d = pins_s[0];
      end else begin
        line_d = tx_serial;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_line_q  <= 1'b1;
      pin_o_q    <= 1'b1;
      pin_oe_q   <= 1'b1;
      released_q <= 1'b0;
    end else if (deep) begin
      rx_line_q  <= 1'b1;
      pin_o_q    <= 1'b1;
      pin_oe_q   <= 1'b1;
      released_q <= 1'b0;
    end else if (run) begin
      rx_line_q  <= line_d;
      pin_o_q    <= tx_serial;
      // transmitter lets go of the pin only in single-wire receive
      pin_oe_q   <= !(cfg.loopback_enable && cfg.loop_source_select
                      && !cfg.single_wire_direction);
      released_q <= cfg.loopback_enable;
    end
  end

  // idle counter; saturates so one quiet stretch wakes only once
  assign char_len = cfg.nine_bit ? CHAR_BITS_9 : CHAR_BITS_8;
  assign idle_hit = run && bit_tick && rx_line_q && !quiet_hold_q
                    && idle_cnt_q == char_len - 4'h1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_q   <= IDLE_CNT_RST;
      quiet_hold_q <= 1'b0;
    end else if (deep) begin
      idle_cnt_q   <= IDLE_CNT_RST;
      quiet_hold_q <= 1'b0;
    end else if (run) begin
      if (bit_tick && !rx_line_q) begin
        idle_cnt_q   <= IDLE_CNT_RST;
        quiet_hold_q <= cfg.quiet_count_start_select;
      end else if (rx_char_valid && quiet_hold_q) begin
        quiet_hold_q <= 1'b0;
      end else if (bit_tick && !quiet_hold_q && idle_cnt_q != char_len) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
    end
  end

  // address mark is seen at the msb sample, ahead of the stop bit
  assign addr_hit = run && cfg.wake_sel && rx_bit_tick && rx_bit_val
                    && rx_bit_pos == (cfg.nine_bit ? MSB_POS_9 : MSB_POS_8);
  assign wake_now = (idle_hit && !cfg.wake_sel) || addr_hit;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_q <= 1'b0;
    end else if (deep) begin
      sleep_q <= 1'b0;
    end else if (run) begin
      if (sleep_q && wake_now) begin
        sleep_q <= 1'b0;
      end else if (sleep_set) begin
        sleep_q <= 1'b1;
      end
    end
  end

  // two-step clear: status read with rx full, idle or overrun up, then data read
  assign clr_now = seq_q == SEQ_ARMED && data_read;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_q <= SEQ_IDLE;
    end else if (deep) begin
      seq_q <= SEQ_IDLE;
    end else if (run) begin
      unique case (seq_q)
        SEQ_IDLE: begin
          if (status_read && (rx_full_q || idle_q || overrun_q)) begin
            seq_q <= SEQ_ARMED;
          end
        end
        SEQ_ARMED: begin
          if (data_read) begin
            seq_q <= SEQ_IDLE;
          end
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // a clearing data read in the same cycle frees the buffer for the new word
  assign take      = run && rx_char_valid && !sleep_q && (!rx_full_q || clr_now);
  assign ovr       = run && rx_char_valid && !sleep_q && rx_full_q && !clr_now;
  assign quiet_set = idle_hit && !sleep_q && idle_arm_q;

  // later assignments win, so a set beats a same-cycle clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_full_q  <= 1'b0;
      idle_q     <= 1'b0;
      overrun_q  <= 1'b0;
      noise_q    <= 1'b0;
      framing_q  <= 1'b0;
      parity_q   <= 1'b0;
      idle_arm_q <= 1'b0;
      rx_data_q  <= '0;
    end else if (deep) begin
      rx_full_q  <= 1'b0;
      idle_q     <= 1'b0;
      overrun_q  <= 1'b0;
      noise_q    <= 1'b0;
      framing_q  <= 1'b0;
      parity_q   <= 1'b0;
      idle_arm_q <= 1'b0;
      rx_data_q  <= '0;
    end else if (run) begin
      if (clr_now) begin
        rx_full_q <= 1'b0;
        idle_q    <= 1'b0;
        overrun_q <= 1'b0;
        noise_q   <= 1'b0;
        framing_q <= 1'b0;
        parity_q  <= 1'b0;
      end
      if (take) begin
        rx_full_q  <= 1'b1;
        noise_q    <= rx_char.noise;
        framing_q  <= rx_char.framing;
        parity_q   <= rx_char.parity;
        idle_arm_q <= 1'b1;
        rx_data_q  <= cfg.nine_bit ? rx_char.data
                                   : {1'b0, rx_char.data[DATA_W-1:0]};
      end
      if (ovr) begin
        overrun_q <= 1'b1;
      end
      if (quiet_set) begin
        idle_q     <= 1'b1;
        idle_arm_q <= 1'b0;
      end
    end
  end

  // transmit buffer; stalls the host through tx_wr_ready
  assign pop = run && fifo_valid && shifter_free && !tx_load_q;

  tx_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .clr       (deep),
    .en        (run),
    .in_valid  (tx_wr_valid),
    .in_data   (tx_wr_data),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_head),
    .out_ready (pop)
  );

  // ninth bit is a held level, sampled only at the move into the shifter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_load_q <= 1'b0;
      tx_word_q <= '0;
      tx_done_q <= 1'b1;
    end else if (deep) begin
      tx_load_q <= 1'b0;
      tx_word_q <= '0;
      tx_done_q <= 1'b1;
    end else if (run) begin
      tx_load_q <= pop;
      if (pop) begin
        tx_word_q <= {cfg.nine_bit && tx_ninth_bit, fifo_head};
      end
      tx_done_q <= shifter_idle && !fifo_valid && !tx_load_q && !pop;
    end
  end

  assign flags_all = '{tx_empty: fifo_ready, tx_done: tx_done_q,
                       rx_full: rx_full_q, idle: idle_q, overrun: overrun_q,
                       noise: noise_q, framing: framing_q, parity: parity_q};

  // requests are levels that follow the flags while enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_irq_q  <= 1'b0;
      rx_irq_q  <= 1'b0;
      err_irq_q <= 1'b0;
    end else if (deep) begin
      tx_irq_q  <= 1'b0;
      rx_irq_q  <= 1'b0;
      err_irq_q <= 1'b0;
    end else if (run) begin
      tx_irq_q  <= |(flags_all & irq_en & TX_GRP);
      rx_irq_q  <= |(flags_all & irq_en & RX_GRP);
      err_irq_q <= |(flags_all & irq_en & ERR_GRP);
    end
  end

  assign tx_wr_ready        = fifo_ready;
  assign tx_load            = tx_load_q;
  assign tx_word            = tx_word_q;
  assign serial_out_pin_o   = pin_o_q;
  assign serial_out_pin_oe  = pin_oe_q;
  assign serial_in_released = released_q;
  assign rx_line            = rx_line_q;
  assign receiver_sleep     = sleep_q;
  assign flags              = flags_all;
  assign rx_data            = rx_data_q;
  assign rx_ninth_bit       = rx_data_q[DATA_W];
  assign tx_irq             = tx_irq_q;
  assign rx_irq             = rx_irq_q;
  assign err_irq            = err_irq_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_idle_wake_sleep: assert property (idle_hit && !cfg.wake_sel && sleep_q |=> !sleep_q)
    else $error("idle wakeup left receiver asleep");
  a_wake_no_quiet: assert property (idle_hit && sleep_q && !deep |=> idle_q == $past(idle_q)
                                    && rx_full_q == $past(rx_full_q))
    else $error("waking idle character set a flag");
  a_quiet_hold_zero: assert property (run && quiet_hold_q && bit_tick |=> idle_cnt_q == IDLE_CNT_RST)
    else $error("idle count advanced before stop bit passed");
  a_addr_wake: assert property (addr_hit && sleep_q && !deep |=> !sleep_q)
    else $error("address mark did not wake receiver");
  a_full_clear_seq: assert property ($fell(rx_full_q) |-> $past(clr_now) || $past(deep))
    else $error("rx full cleared without status then data read");
  a_quiet_rearm: assert property (run && !idle_arm_q && !take ##1 !idle_arm_q |-> !$rose(idle_q))
    else $error("quiet flag set again without a new character");
  a_err_with_full: assert property (take && !deep && rx_char.framing |=> framing_q && rx_full_q)
    else $error("framing error not set with rx full");
  a_overrun_keep: assert property (ovr && !deep |=> overrun_q && rx_data_q == $past(rx_data_q))
    else $error("overrun did not keep old data");
  a_ninth_copy: assert property (pop && !deep |=> tx_load_q
                                 && tx_word_q[FIFO_W] == ($past(cfg.nine_bit) && $past(tx_ninth_bit)))
    else $error("ninth bit not copied on load");
  a_txe_request: assert property (run && fifo_ready && irq_en.tx_empty |=> tx_irq_q || deep)
    else $error("tx empty request missing");
  a_loop_feed: assert property (run && cfg.loopback_enable && !cfg.loop_source_select |=> rx_line_q == $past(tx_serial) || deep)
    else $error("loop mode receiver not fed by transmitter");
  a_wire_release: assert property (run && cfg.loopback_enable && cfg.loop_source_select
                                   && !cfg.single_wire_direction |=> !pin_oe_q || deep)
    else $error("transmitter still drives pin in single-wire receive");
  a_sleep_mute: assert property (run && sleep_q && !wake_now && !clr_now |=> rx_full_q == $past(rx_full_q)
                                 && overrun_q == $past(overrun_q))
    else $error("receiver flag changed while asleep");
  a_stop_hold: assert property (stop_mode == STOP_LIGHT |=> sleep_q == $past(sleep_q) && rx_full_q == $past(rx_full_q))
    else $error("state changed during light stop");
endmodule
`default_nettype wire

// [bench/serial_remote.sv]
`default_nettype none
module serial_remote
  import uart_wakeup_pkg::*;
(
  input  wire logic     clk,  // module clock
  input  wire logic     go,   // pulse, send chr
  input  wire rx_char_s chr,  // character to send
  output logic          tick, // data bit sampled
  output logic    [3:0] pos,  // its position
  output logic          val,  // its value
  output logic          done, // stop bit seen
  output rx_char_s      out   // character delivered
);
  logic [3:0] n_q = 4'hF;
  initial {tick, pos, val, done, out} = '0;
  // whole 9-bit unit, lsb first
  always @(posedge clk) begin
    tick <= 1'h0;
    done <= 1'h0;
    if (go) begin
      out <= chr;
      n_q <= 4'h0;
    end else if (n_q < 4'h9) begin
      tick <= 1'h1;
      pos  <= n_q;
      val  <= out.data[n_q];
      n_q  <= n_q + 4'h1;
    end else if (n_q == 4'h9) begin
      done <= 1'h1;
      n_q  <= 4'hF;
    end
  end
endmodule
`default_nettype wire

// [bench/uart_wakeup_flags_loop_tb.sv]
`default_nettype none
module uart_wakeup_flags_loop_tb
  import uart_wakeup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rstn = 1'h0, sleep_set = 1'h0, st_rd = 1'h0, dt_rd = 1'h0, t9 = 1'h0, wv = 1'h0;
  logic sf = 1'h0, si = 1'h1, txs = 1'h1, btk = 1'h0, pin = 1'h1, ext = 1'h1, go = 1'h0, wake_seen;
  logic rtk, rval, rdone, wr_rdy, load, po, poe, rel, rxl, slp, r9, tirq, rirq, eirq;
  logic [7:0] wd = 8'h00;
  logic [3:0] rpos;
  logic [8:0] tword, rdata;
  stop_mode_e smode = STOP_NONE;
  cfg_s cfg = '0;
  flags_s ien = '0, flags;
  rx_char_s chr = '0, rxc;
  int errors = 0, checks = 0;
  logic [11:0] lp [4] = '{12'h029, 12'h11B, 12'h1DB, 12'h1B2};
  uart_wakeup_flags_loop i_uart_wakeup_flags_loop (.clk, .rstn, .stop_mode(smode), .cfg, .irq_en(ien),
    .sleep_set, .status_read(st_rd), .data_read(dt_rd), .tx_ninth_bit(t9), .tx_wr_valid(wv), .tx_wr_data(wd),
    .tx_wr_ready(wr_rdy), .shifter_free(sf), .shifter_idle(si), .tx_serial(txs), .tx_load(load),
    .tx_word(tword), .bit_tick(btk), .rx_bit_tick(rtk), .rx_bit_pos(rpos), .rx_bit_val(rval),
    .rx_char_valid(rdone), .rx_char(rxc), .serial_in_pin(pin), .serial_out_pin_i(poe ? po : ext),
    .serial_out_pin_o(po), .serial_out_pin_oe(poe), .serial_in_released(rel), .rx_line(rxl),
    .receiver_sleep(slp), .flags, .rx_data(rdata), .rx_ninth_bit(r9), .tx_irq(tirq), .rx_irq(rirq),
    .err_irq(eirq));
  serial_remote i_serial_remote (.clk, .go, .chr, .tick(rtk), .pos(rpos), .val(rval), .done(rdone), .out(rxc));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic await(ref logic s);
    int i;
    for (i = 0; i < 30 && s !== 1'h1; i++) @(posedge clk);
    if (i == 30) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic recv(input logic [11:0] c);
    @(posedge clk) begin
      chr <= c;
      go  <= 1'h1;
    end
    @(posedge clk) go <= 1'h0;
    await(rdone);
    wake_seen = slp;
    cyc(2);
  endtask
  task automatic clr(input logic s);
    @(posedge clk) st_rd <= s;
    @(posedge clk) begin
      st_rd <= 1'h0;
      dt_rd <= 1'h1;
    end
    @(posedge clk) dt_rd <= 1'h0;
    cyc(2);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) btk <= 1'h1;
      @(posedge clk) btk <= 1'h0;
    end
    cyc(2);
  endtask
  // one low bit time restarts the quiet count
  task automatic dip;
    @(posedge clk) pin <= 1'h0;
    cyc(4);
    tick(1);
    @(posedge clk) pin <= 1'h1;
    cyc(4);
  endtask
  task automatic nap(input logic [5:0] c);
    @(posedge clk) begin
      cfg       <= c;
      sleep_set <= 1'h1;
    end
    @(posedge clk) sleep_set <= 1'h0;
  endtask
  task automatic addr_wake(input logic [5:0] c, input logic [8:0] miss, input logic [8:0] hit);
    nap(c);
    recv({miss, 3'h0});
    chk({slp, flags}, 9'h1C0);
    recv({hit, 3'h0});
    chk(wake_seen, 1'h0);
    chk(flags, 9'h0E0);
    chk({r9, rdata[7:0]}, hit);
    clr(1'h1);
  endtask
  task automatic idle_wake(input logic [5:0] c, input int n);
    nap(c);
    dip();
    if (c[3]) begin
      tick(n);
      chk(slp, 1'h1);
      recv(12'h000);
    end
    tick(n - 1);
    chk(slp, 1'h1);
    tick(1);
    chk({slp, flags}, 9'h0C0);
    dip();
    recv(12'h330);
    tick(n);
    chk(flags, 9'h0F0);
    clr(1'h1);
    tick(n);
    chk(flags, 9'h0C0);
  endtask
  initial forever #50 clk = ~clk;
  initial begin
    cyc(10);
    rstn <= 1'h1;
    cyc(2);
    chk({slp, flags}, 9'h0C0);
    @(posedge clk) ien <= 8'hFF;
    recv({9'h05A, 3'h5});
    chk(flags, 9'h0E5);
    chk({rirq, eirq, tirq, rdata[5:0]}, 9'h1DA);
    recv({9'h0A5, 3'h2});
    chk(flags, 9'h0ED);
    chk(rdata, 9'h05A);
    clr(1'h0);
    chk(flags, 9'h0ED);
    clr(1'h1);
    chk(flags, 9'h0C0);
    $display("test receive done");
    addr_wake(6'h10, 9'h07F, 9'h080);
    addr_wake(6'h30, 9'h0FF, 9'h100);
    idle_wake(6'h00, 10);
    idle_wake(6'h28, 11);
    $display("test wakeup done");
    // shifter busy and stalled: the 17th word must be dropped
    @(posedge clk) si <= 1'h0;
    for (int k = 0; k < 17; k++) begin
      @(posedge clk) begin
        wv <= 1'h1;
        wd <= 8'(k);
      end
    end
    @(posedge clk) wv <= 1'h0;
    cyc(2);
    chk({tirq, wr_rdy, flags[7:6]}, 9'h000);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk) begin
        t9 <= k[0];
        sf <= 1'h1;
      end
      await(load);
      sf <= 1'h0;
      chk(tword, {k[0], 8'(k)});
      cyc(3);
    end
    chk(flags, 9'h080);
    @(posedge clk) begin
      si  <= 1'h1;
      ien <= 8'h40;
    end
    cyc(3);
    chk({tirq, flags}, 9'h1C0);
    $display("test transmit done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) begin
        cfg              <= lp[k][11:6];
        {txs, pin, ext}  <= lp[k][5:3];
      end
      cyc(5);
      chk({rxl, rel, poe}, lp[k][2:0]);
      chk(po, lp[k][5]);
    end
    @(posedge clk) begin
      cfg <= '0;
      txs <= 1'h1;
      pin <= 1'h1;
    end
    $display("test loop done");
    // nothing in flight when stop is entered
    recv({9'h011, 3'h0});
    @(posedge clk) smode <= STOP_LIGHT;
    clr(1'h1);
    @(posedge clk) smode <= STOP_NONE;
    cyc(2);
    chk(flags, 9'h0E0);
    @(posedge clk) smode <= STOP_DEEP;
    cyc(2);
    chk(rdata, 9'h000);
    chk(flags, 9'h0C0);
    $display("test stop done");
    wrap_up();
  end
endmodule
`default_nettype wire
